/* hdl/input_interrupter.sv */
// Purpose: interrupt registers, arrival queue and bus interrupter
// Assumes: AHB-Lite register slave, zero wait states, OKAY always
// Notes: bus-side strobes are active low and synchronous to hclk
//
// Local design decisions: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
module input_interrupter (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [15:0] din,
  input wire logic [2:0] irq_level_jumper,
  input wire logic sysclk,
  input wire logic board_sel,
  input wire logic ds0_n,
  input wire logic ds1_n,
  input wire logic iackin_n,
  input wire logic [2:0] ack_level,
  output logic [6:0] irq_out,
  output logic [6:0] irq_oe,
  output logic iackout_n,
  output logic [7:0] vme_d_out,
  output logic vme_d_oe,
  output logic dtack_out,
  output logic dtack_oe
);
  chan_cfg_if cb ();

  // register state
  logic [3:0] board;
  logic [7:0] pend;
  logic [7:0] ien;
  logic [7:0] pol;
  logic [7:0] type_sel;
  logic [7:0] pat;
  logic [7:0] vec [0:7];
  logic [3:0] next_board;
  logic [7:0] next_pend;
  logic [7:0] next_ien;
  logic [7:0] next_pol;
  logic [7:0] next_type_sel;
  logic [7:0] next_pat;
  logic [7:0] next_vec [0:7];
  // bus slave state
  logic wr_act;
  logic [7:0] wr_addr;
  logic next_wr_act;
  logic [7:0] next_wr_addr;
  logic [31:0] next_hrdata;
  logic [7:0] clr_mask;
  logic [7:0] set_req;
  // arrival queue
  logic [2:0] q [0:7];
  logic [3:0] qcnt;
  logic [2:0] next_q [0:7];
  logic [3:0] next_qcnt;
  logic [2:0] head_ch;
  logic [7:0] head_vec;
  // interrupter
  input_irq_pkg::ack_state_t state;
  input_irq_pkg::ack_state_t next_state;
  logic [2:0] cnt;
  logic [2:0] next_cnt;
  logic sysclk_prev;
  logic sysclk_edge;
  logic irq_active;
  logic [6:0] next_irq_oe;
  logic next_iackout_n;
  logic [7:0] next_vme_d;
  logic next_vme_d_oe;
  logic next_dtack_oe;

  // true when the offset hits one of the vector words
  function automatic logic vec_hit(input logic [7:0] a);
    vec_hit = (a >= input_irq_pkg::A_VEC0) && (a <= input_irq_pkg::A_VEC_LAST);
  endfunction : vec_hit

  // highest set channel, for simultaneous arrivals
  function automatic logic [2:0] top_ch(input logic [7:0] m);
    top_ch = 3'h0;
    for (int i = 0; i < input_irq_pkg::NCH; i++) begin
      if (m[i]) begin
        top_ch = 3'(i);
      end
    end
  endfunction : top_ch

  // only the low eight inputs reach the detector
  assign cb.din = din[7:0];
  assign cb.type_sel = type_sel;
  assign cb.pol = pol;
  assign cb.ien = ien;
  assign cb.pat = pat;
  assign cb.gie = board[input_irq_pkg::BOARD_GIE_BIT];
  assign set_req = cb.set_req;

  input_trigger u_trig (
    .hclk(hclk),
    .hresetn(hresetn),
    .cb(cb)
  );

  // address phase capture and read data; a read misses a write still in its data phase, for zero waits
  always_comb begin
    logic [7:0] a;
    a = haddr[7:0];
    next_wr_act = hsel & hready & htrans[1] & hwrite;
    next_wr_addr = a;
    next_hrdata = hrdata;
    if (hsel && hready && htrans[1] && !hwrite) begin
      next_hrdata = 32'h0000_0000;
      case (a)
        input_irq_pkg::A_BOARD: next_hrdata[3:0] = board;
        input_irq_pkg::A_PEND: next_hrdata[7:0] = pend;
        input_irq_pkg::A_IEN: next_hrdata[7:0] = ien;
        input_irq_pkg::A_POL: next_hrdata[7:0] = pol;
        input_irq_pkg::A_TYPE: next_hrdata[7:0] = type_sel;
        input_irq_pkg::A_PAT: next_hrdata[7:0] = pat;
        input_irq_pkg::A_DIN: next_hrdata[15:0] = din;
        default: begin
          if (vec_hit(a) && a[1:0] == 2'b00) begin
            next_hrdata[7:0] = vec[a[4:2]];
          end
        end
      endcase
    end
  end

  // data phase writes; hardware set wins over software clear
  always_comb begin
    next_board = board;
    next_ien = ien;
    next_pol = pol;
    next_type_sel = type_sel;
    next_pat = pat;
    for (int i = 0; i < input_irq_pkg::NCH; i++) begin
      next_vec[i] = vec[i];
    end
    clr_mask = 8'h00;
    if (wr_act) begin
      case (wr_addr)
        input_irq_pkg::A_BOARD: next_board = hwdata[3:0] & input_irq_pkg::BOARD_WMASK;
        input_irq_pkg::A_PEND: clr_mask = hwdata[7:0];
        input_irq_pkg::A_IEN: next_ien = hwdata[7:0];
        input_irq_pkg::A_POL: next_pol = hwdata[7:0];
        input_irq_pkg::A_TYPE: next_type_sel = hwdata[7:0];
        input_irq_pkg::A_PAT: next_pat = hwdata[7:0];
        default: begin
          if (vec_hit(wr_addr) && wr_addr[1:0] == 2'b00) begin
            next_vec[wr_addr[4:2]] = hwdata[7:0];
          end
        end
      endcase
    end
    next_pend = (pend & ~clr_mask) | set_req;
  end

  // queue keeps arrival order; drops cleared, appends new high first
  always_comb begin
    int n;
    n = 0;
    for (int i = 0; i < input_irq_pkg::NCH; i++) begin
      next_q[i] = 3'h0;
    end
    for (int i = 0; i < input_irq_pkg::NCH; i++) begin
      if (4'(i) < qcnt && next_pend[q[i]]) begin
        next_q[n[2:0]] = q[i];
        n = n + 1;
      end
    end
    for (int c = input_irq_pkg::NCH - 1; c >= 0; c--) begin
      if (next_pend[c] && !pend[c]) begin
        next_q[n[2:0]] = 3'(c);
        n = n + 1;
      end
    end
    next_qcnt = 4'(n);
  end

  assign head_ch = q[0];
  assign head_vec = vec[head_ch];
  assign sysclk_edge = sysclk & ~sysclk_prev;
  // request stands while anything is pending; ack does not drop it
  assign irq_active = board[input_irq_pkg::BOARD_GIE_BIT] & (qcnt != 4'h0)
    & (irq_level_jumper != 3'h0);

  // interrupter and transfer acknowledge
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_iackout_n = iackout_n;
    next_vme_d = vme_d_out;
    next_vme_d_oe = vme_d_oe;
    next_dtack_oe = dtack_oe;
    next_irq_oe = 7'h00;
    if (irq_active) begin
      next_irq_oe[irq_level_jumper - 3'h1] = 1'b1;
    end
    case (state)
      input_irq_pkg::ST_IDLE: begin
        if (!iackin_n && !ds0_n) begin
          if (irq_active && ack_level == irq_level_jumper) begin
            next_vme_d = head_vec;
            next_vme_d_oe = 1'b1;
            next_dtack_oe = 1'b1;
            next_state = input_irq_pkg::ST_HOLD;
          end else begin
            next_iackout_n = 1'b0;
            next_state = input_irq_pkg::ST_PASS;
          end
        end else if (iackin_n && board_sel && (!ds0_n || !ds1_n)) begin
          next_cnt = 3'h0;
          next_state = input_irq_pkg::ST_XFER;
        end
      end
      input_irq_pkg::ST_XFER: begin
        if (ds0_n && ds1_n) begin
          next_state = input_irq_pkg::ST_IDLE;
        end else if (sysclk_edge) begin
          if (cnt == input_irq_pkg::DTACK_SYSCLKS - 3'h1) begin
            next_dtack_oe = 1'b1;
            next_state = input_irq_pkg::ST_HOLD;
          end else begin
            next_cnt = cnt + 3'h1;
          end
        end
      end
      input_irq_pkg::ST_HOLD: begin
        if (ds0_n && ds1_n) begin
          next_vme_d_oe = 1'b0;
          next_dtack_oe = 1'b0;
          next_state = input_irq_pkg::ST_IDLE;
        end
      end
      input_irq_pkg::ST_PASS: begin
        if (iackin_n) begin
          next_iackout_n = 1'b1;
          next_state = input_irq_pkg::ST_IDLE;
        end
      end
      default: begin
        next_state = input_irq_pkg::ST_IDLE;
      end
    endcase
  end

  // all state registered here; the bus error output hresp is held at OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      board <= input_irq_pkg::BOARD_RESET;
      pend <= input_irq_pkg::CH_RESET;
      ien <= input_irq_pkg::CH_RESET;
      pol <= input_irq_pkg::CH_RESET;
      type_sel <= input_irq_pkg::CH_RESET;
      pat <= input_irq_pkg::CH_RESET;
      for (int i = 0; i < input_irq_pkg::NCH; i++) begin
        vec[i] <= input_irq_pkg::VEC_RESET;
        q[i] <= 3'h0;
      end
      qcnt <= 4'h0;
      wr_act <= 1'b0;
      wr_addr <= 8'h00;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      state <= input_irq_pkg::ST_IDLE;
      cnt <= 3'h0;
      sysclk_prev <= 1'b0;
      irq_out <= 7'h00;
      irq_oe <= 7'h00;
      iackout_n <= 1'b1;
      vme_d_out <= 8'h00;
      vme_d_oe <= 1'b0;
      dtack_out <= 1'b0;
      dtack_oe <= 1'b0;
    end else begin
      board <= next_board;
      pend <= next_pend;
      ien <= next_ien;
      pol <= next_pol;
      type_sel <= next_type_sel;
      pat <= next_pat;
      for (int i = 0; i < input_irq_pkg::NCH; i++) begin
        vec[i] <= next_vec[i];
        q[i] <= next_q[i];
      end
      qcnt <= next_qcnt;
      wr_act <= next_wr_act;
      wr_addr <= next_wr_addr;
      hrdata <= next_hrdata;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      state <= next_state;
      cnt <= next_cnt;
      sysclk_prev <= sysclk;
      irq_out <= 7'h00;
      irq_oe <= next_irq_oe;
      iackout_n <= next_iackout_n;
      vme_d_out <= next_vme_d;
      vme_d_oe <= next_vme_d_oe;
      dtack_out <= 1'b0;
      dtack_oe <= next_dtack_oe;
    end
  end

  // checks on the block's own outputs and flags
  default clocking dc @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_gie_blocks_irq: assert property (!board[3] |=> irq_oe == 7'h00)
    else $error("request driven with global enable clear");
  a_pend_clear: assert property (wr_act && wr_addr == input_irq_pkg::A_PEND
    |=> (pend & $past(clr_mask) & ~$past(set_req)) == 8'h00)
    else $error("pending flag survived write-one clear");
  a_set_wins: assert property (set_req != 8'h00 |=> (pend & $past(set_req)) == $past(set_req))
    else $error("set request lost");
  a_req_holds: assert property (board[3] && pend != 8'h00 && irq_level_jumper != 3'h0 |=> irq_oe != 7'h00)
    else $error("request dropped while pending");
  a_level_onehot: assert property (irq_oe != 7'h00 |-> $onehot(irq_oe))
    else $error("more than one request level driven");
  a_vector_match: assert property (state == input_irq_pkg::ST_IDLE && !iackin_n && !ds0_n && irq_active
    && ack_level == irq_level_jumper |=> vme_d_oe && dtack_oe && vme_d_out == $past(head_vec) && iackout_n)
    else $error("vector not returned on level match");
  a_pass_on: assert property (state == input_irq_pkg::ST_IDLE && !iackin_n && !ds0_n
    && ack_level != irq_level_jumper |=> !iackout_n && !vme_d_oe ##1 !vme_d_oe)
    else $error("acknowledge not passed on mismatch");
  a_dtack_delay: assert property ($rose(dtack_oe) && !vme_d_oe
    |-> $past(cnt) == input_irq_pkg::DTACK_SYSCLKS - 3'h1)
    else $error("transfer acknowledge at wrong delay");
  a_tie_order: assert property (qcnt == 4'h0 && pend == 8'h00 && set_req != 8'h00
    |=> head_ch == top_ch($past(set_req)) && qcnt != 4'h0)
    else $error("simultaneous arrivals not highest first");
endmodule : input_interrupter
`default_nettype wire

/* hdl/input_irq_pkg.sv */
// Purpose: shared constants and types for the input interrupter
// Assumes: 200 MHz hclk, 16 MHz bus clock sampled as a plain input
// Notes: register offsets are byte addresses on the AHB-Lite slave
package input_irq_pkg;
  localparam int NCH = 8;
  localparam int DIN_W = 16;
  // register byte offsets, one aligned word each
  localparam logic [7:0] A_BOARD = 8'h00;
  localparam logic [7:0] A_PEND = 8'h04;
  localparam logic [7:0] A_IEN = 8'h08;
  localparam logic [7:0] A_POL = 8'h0C;
  localparam logic [7:0] A_TYPE = 8'h10;
  localparam logic [7:0] A_PAT = 8'h14;
  localparam logic [7:0] A_DIN = 8'h18;
  localparam logic [7:0] A_VEC0 = 8'h20;
  localparam logic [7:0] A_VEC_LAST = 8'h3C;
  // board status fields
  localparam int BOARD_GIE_BIT = 3;
  localparam logic [3:0] BOARD_WMASK = 4'hB;
  localparam logic [3:0] BOARD_RESET = 4'h0;
  localparam logic [7:0] CH_RESET = 8'h00;
  localparam logic [7:0] VEC_RESET = 8'h00;
  localparam int PAT_CH = 7;
  // acknowledge delay for data transfers, counted in bus clock edges
  localparam int SYSCLK_MHZ = 16;
  localparam int DTACK_DELAY_NS = 125;
  localparam int DTACK_SYSCLKS_I = (DTACK_DELAY_NS * SYSCLK_MHZ + 999) / 1000;
  localparam logic [2:0] DTACK_SYSCLKS = DTACK_SYSCLKS_I[2:0];

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_XFER = 2'b01,
    ST_HOLD = 2'b10,
    ST_PASS = 2'b11
  } ack_state_t;
endpackage : input_irq_pkg

/* hdl/chan_cfg_if.sv */
// Purpose: carries channel configuration to the trigger detector
// Assumes: single hclk domain
// Notes: set_req returns set requests per channel; edge hits last one cycle, level hits last while the level holds
`timescale 1ns/100ps
`default_nettype none
interface chan_cfg_if;
  logic [7:0] din;
  logic [7:0] type_sel;
  logic [7:0] pol;
  logic [7:0] ien;
  logic [7:0] pat;
  logic gie;
  logic [7:0] set_req;
  modport cfg (output din, type_sel, pol, ien, pat, gie, input set_req);
  modport det (input din, type_sel, pol, ien, pat, gie, output set_req);
endinterface : chan_cfg_if
`default_nettype wire

/* hdl/input_trigger.sv */
// Purpose: per-channel trigger and pattern detection for channels 0-7
// Assumes: inputs already debounced and synchronous to hclk
// Notes: set_req is combinational; the owner of the flags registers it
`timescale 1ns/100ps
`default_nettype none
module input_trigger (
  input wire logic hclk,
  input wire logic hresetn,
  chan_cfg_if.det cb
);
  logic [7:0] din_prev;
  logic [7:0] next_din_prev;
  logic [7:0] chan_hit;
  logic pat_hit;

  // per channel: edge in either direction, or level equal to polarity
  for (genvar i = 0; i < input_irq_pkg::NCH; i++) begin : g_ch
    assign chan_hit[i] = cb.ien[i] &
      (cb.type_sel[i] ? (cb.din[i] ^ din_prev[i]) : (cb.din[i] ~^ cb.pol[i]));
  end

  // all pattern members at their level, at least one member
  always_comb begin
    next_din_prev = cb.din;
    pat_hit = cb.gie & (|cb.pat) & (&(~cb.pat | (cb.din ~^ cb.pol)));
    cb.set_req = chan_hit;
    cb.set_req[input_irq_pkg::PAT_CH] = chan_hit[input_irq_pkg::PAT_CH] | pat_hit;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      din_prev <= input_irq_pkg::CH_RESET;
    end else begin
      din_prev <= next_din_prev;
    end
  end
endmodule : input_trigger
`default_nettype wire

/* verification/vme_host_model.sv */
// Purpose: host side of the bus, acknowledge and transfer cycles
// Assumes: host lines change just after hclk edges
// Notes: released strobes read high, as with backplane pull-ups
`timescale 1ns/100ps
`default_nettype none
module vme_host_model (
  input wire logic hclk,
  input wire logic iackout_n,
  input wire logic [7:0] vme_d_out,
  input wire logic vme_d_oe,
  input wire logic dtack_oe,
  output logic sysclk,
  output logic board_sel,
  output logic ds0_n,
  output logic ds1_n,
  output logic iackin_n,
  output logic [2:0] ack_level
);
  // idle bus at time zero
  initial begin
    sysclk = 1'b0;
    board_sel = 1'b0;
    ds0_n = 1'b1;
    ds1_n = 1'b1;
    iackin_n = 1'b1;
    ack_level = 3'h0;
  end
  // free running system clock, unrelated in phase to hclk
  always #31.2 sysclk = ~sysclk;
  // acknowledge cycle; hold stretches the strobe like a slow host
  task iack(input logic [2:0] lvl, input int hold, output logic [7:0] vec, output logic hit, output logic pass);
    int n;
    n = 0;
    hit = 1'b0;
    pass = 1'b0;
    vec = 8'h00;
    @(posedge hclk);
    iackin_n <= 1'b0;
    ds0_n <= 1'b0;
    ack_level <= lvl;
    while (!hit && !pass && n < 40) begin
      @(posedge hclk);
      n++;
      hit = (dtack_oe === 1'b1) && (vme_d_oe === 1'b1);
      pass = (iackout_n === 1'b0);
      vec = vme_d_out;
    end
    repeat (hold) @(posedge hclk);
    iackin_n <= 1'b1;
    ds0_n <= 1'b1;
    ack_level <= ~lvl; // released address lines driven to the complement of the level
    repeat (3) @(posedge hclk);
  endtask : iack
  // data transfer, counts hclk cycles until the acknowledge
  task xfer(output int cyc);
    cyc = 0;
    @(posedge hclk);
    board_sel <= 1'b1;
    ds1_n <= 1'b0;
    while (dtack_oe !== 1'b1 && cyc < 60) begin
      @(posedge hclk);
      cyc++;
    end
    board_sel <= 1'b0;
    ds1_n <= 1'b1;
    repeat (3) @(posedge hclk);
  endtask : xfer
endmodule : vme_host_model
`default_nettype wire

/* verification/tb.sv */
// Purpose: self-checking bench for the input interrupter
// Assumes: zero wait AHB-Lite slave, host model on the far side
// Notes: expectations come from bench functions, bench variables and literals
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [15:0] din = 16'h0000;
  logic [2:0] jmp = 3'h7;
  logic [31:0] hrdata;
  logic hreadyout, iackout_n, vme_d_oe, dtack_oe, sysclk, board_sel, ds0_n, ds1_n, iackin_n, hresp, dtack_out;
  logic [6:0] irq_oe, irq_out;
  logic [7:0] vme_d_out;
  logic [2:0] ack_level;
  logic [7:0] vec [8];
  int seed = 67741;
  int bad_count = 0;
  int n_tests = 0;

  // 200 MHz clock
  always #2.5 hclk = ~hclk;

  input_interrupter u_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .din(din), .irq_level_jumper(jmp), .sysclk(sysclk),
    .board_sel(board_sel), .ds0_n(ds0_n), .ds1_n(ds1_n), .iackin_n(iackin_n),
    .ack_level(ack_level), .irq_out(irq_out), .irq_oe(irq_oe), .iackout_n(iackout_n),
    .vme_d_out(vme_d_out), .vme_d_oe(vme_d_oe), .dtack_out(dtack_out), .dtack_oe(dtack_oe)
  );
  vme_host_model u_host (
    .hclk(hclk), .iackout_n(iackout_n), .vme_d_out(vme_d_out), .vme_d_oe(vme_d_oe),
    .dtack_oe(dtack_oe), .sysclk(sysclk), .board_sel(board_sel), .ds0_n(ds0_n),
    .ds1_n(ds1_n), .iackin_n(iackin_n), .ack_level(ack_level)
  );

  // pending flags expected from a level setup
  function automatic logic [31:0] lvl_exp(input logic [7:0] d, input logic [7:0] p, input logic [7:0] e);
    return {24'h0, ~(d ^ p) & e};
  endfunction : lvl_exp
  // request enables expected for one jumper level
  function automatic logic [6:0] irq_exp(input logic [2:0] lvl, input logic on);
    return on ? 7'h01 << (lvl - 3'h1) : 7'h00;
  endfunction : irq_exp
  task results();
    if (bad_count == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : results
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // one single transfer; read data taken at the data phase edge
  task bus(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : bus
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(a, 1'b1, d, x);
  endtask : wr
  task rdchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] x;
    bus(a, 1'b0, 32'h0, x);
    chk(x, e);
  endtask : rdchk
  // new inputs, then time for flags to land
  task setdin(input logic [15:0] v);
    @(posedge hclk);
    din <= v;
    repeat (3) @(posedge hclk);
  endtask : setdin
  task irqchk(input logic on);
    repeat (3) @(posedge hclk);
    chk({25'h0, irq_oe}, {25'h0, irq_exp(jmp, on)});
    // open-drain data levels stay low, response always okay
    chk({23'h0, hresp, irq_out, dtack_out}, 32'h0);
  endtask : irqchk
  // matching acknowledge, host of random speed
  task ackchk(input logic [7:0] e);
    logic [7:0] v;
    logic h;
    logic p;
    u_host.iack(jmp, 1 + ($unsigned($random(seed)) % 8), v, h, p);
    chk({23'h0, h, v}, {23'h0, 1'b1, e});
  endtask : ackchk
  // global enable off first and on last
  task cfg(input logic [7:0] ty, input logic [7:0] pol, input logic [7:0] ien, input logic [7:0] pat);
    wr(input_irq_pkg::A_BOARD, 32'h0);
    wr(input_irq_pkg::A_TYPE, {24'h0, ty});
    wr(input_irq_pkg::A_POL, {24'h0, pol});
    wr(input_irq_pkg::A_PAT, {24'h0, pat});
    wr(input_irq_pkg::A_IEN, {24'h0, ien});
    wr(input_irq_pkg::A_PEND, 32'hFF);
    wr(input_irq_pkg::A_BOARD, 32'h8);
  endtask : cfg

  initial begin : main
    logic [7:0] p, e, m, v_v;
    logic v_h, v_p;
    int c;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    rdchk(input_irq_pkg::A_PAT, 32'h0);
    rdchk(input_irq_pkg::A_BOARD, 32'h0);
    rdchk(8'h44, 32'h0);
    for (int i = 0; i < 8; i++) begin
      vec[i] = 8'($random(seed));
      wr(input_irq_pkg::A_VEC0 + 8'(4 * i), {24'h0, vec[i]});
    end
    for (int i = 0; i < 8; i++) begin
      rdchk(input_irq_pkg::A_VEC0 + 8'(4 * i), {24'h0, vec[i]});
    end
    // random level setups, upper inputs random too
    for (int k = 0; k < 8; k++) begin
      p = 8'($random(seed));
      e = 8'($random(seed));
      setdin(16'($random(seed)));
      cfg(8'h00, p, e, 8'h00);
      rdchk(input_irq_pkg::A_PEND, lvl_exp(din[7:0], p, e));
      irqchk(lvl_exp(din[7:0], p, e) != 32'h0);
      wr(input_irq_pkg::A_BOARD, 32'h0);
      irqchk(1'b0);
    end
    // change of state on channels 1 to 7, every request level in turn
    setdin(16'h0000);
    cfg(8'hFF, 8'h00, 8'hFF, 8'h00);
    setdin(16'hFF00);
    rdchk(input_irq_pkg::A_PEND, 32'h0);
    for (int l = 1; l < 8; l++) begin
      jmp <= 3'(l);
      m = 8'h01 << l;
      setdin({8'h00, m});
      rdchk(input_irq_pkg::A_PEND, {24'h0, m});
      irqchk(1'b1);
      u_host.iack(3'(l % 7 + 1), 1, v_v, v_h, v_p);
      chk({31'h0, v_p}, 32'h1);
      ackchk(vec[l]);
      irqchk(1'b1);
      wr(input_irq_pkg::A_PEND, {24'h0, m});
      irqchk(1'b0);
      setdin(16'h0000);
      rdchk(input_irq_pkg::A_PEND, {24'h0, m});
      wr(input_irq_pkg::A_PEND, 32'hFF);
    end
    // two arrivals together, then a later one
    jmp <= 3'h3;
    setdin(16'h0024);
    setdin(16'h0064);
    wr(input_irq_pkg::A_PEND, 32'h0);
    rdchk(input_irq_pkg::A_PEND, 32'h64);
    ackchk(vec[5]);
    wr(input_irq_pkg::A_PEND, 32'h20);
    irqchk(1'b1);
    ackchk(vec[2]);
    wr(input_irq_pkg::A_PEND, 32'h04);
    ackchk(vec[6]);
    wr(input_irq_pkg::A_PEND, 32'h40);
    irqchk(1'b0);
    // lasting level comes back after a clear until masked
    setdin(16'h0000);
    cfg(8'h00, 8'h00, 8'h01, 8'h00);
    wr(input_irq_pkg::A_PEND, 32'h01);
    rdchk(input_irq_pkg::A_PEND, 32'h01);
    irqchk(1'b1);
    wr(input_irq_pkg::A_IEN, 32'h0);
    wr(input_irq_pkg::A_PEND, 32'h01);
    rdchk(input_irq_pkg::A_PEND, 32'h0);
    irqchk(1'b0);
    // stuck level: flip polarity, then the channel may come back on
    wr(input_irq_pkg::A_POL, 32'h01);
    wr(input_irq_pkg::A_IEN, 32'h01);
    rdchk(input_irq_pkg::A_PEND, 32'h0);
    // pattern of channels 1 and 3 high
    cfg(8'h00, 8'h0A, 8'h00, 8'h0A);
    rdchk(input_irq_pkg::A_PEND, 32'h0);
    setdin(16'h0002);
    rdchk(input_irq_pkg::A_PEND, 32'h0);
    setdin(16'h000A);
    rdchk(input_irq_pkg::A_PEND, 32'h80);
    ackchk(vec[7]);
    wr(input_irq_pkg::A_BOARD, 32'h0);
    wr(input_irq_pkg::A_PEND, 32'hFF);
    rdchk(input_irq_pkg::A_PEND, 32'h0);
    // transfer acknowledge comes two system clock edges in
    u_host.xfer(c);
    chk(32'(c >= 14 && c <= 29), 32'h1);
    results();
  end

  // hang guard, far beyond the thousand or so cycles used
  initial begin : watchdog
    #200000;
    bad_count++;
    results();
  end
endmodule : tb
`default_nettype wire
